// *** shared/phy_led_ctrl_regs.vh ***
// register offsets, field positions and timing constants for the led/misc block
`ifndef PHY_LED_CTRL_REGS_VH
`define PHY_LED_CTRL_REGS_VH

// register indices; byte address is four times the index
`define IDX_LED_OVR 5'h18
`define IDX_MISC_CTL 5'h19
`define IDX_STATUS_IN 5'h1A

// led_direct_override fields
`define LO_SPD_EN 5
`define LO_LNK_EN 4
`define LO_ACT_EN 3
`define LO_SPD_VAL 2
`define LO_LNK_VAL 1
`define LO_ACT_VAL 0
`define LO_MASK 16'h003F

// phy_misc_control fields
`define MC_XOVER_EN 15
`define MC_FORCE_XOVER 14
`define MC_PAUSE_RX 13
`define MC_PAUSE_TX 12
`define MC_FORCE_ERR 11
`define MC_SEQ_SEL 10
`define MC_PASS 9
`define MC_RUN 8
`define MC_BYPASS 7
`define MC_MODE_HI 6
`define MC_MODE_LO 5

// advertisement pause bits (symmetric, asymmetric)
`define ADV_SYM 10
`define ADV_ASYM 11

// led stretch and blink timing
`define STRETCH_MS 50
`define BLINK_MS 50
`define CLK_KHZ 125000

`endif

// *** rtl/phy_led_mdix_bist_control.v ***
// led override and phy misc control registers with led mode logic
`default_nettype none
`include "phy_led_ctrl_regs.vh"

module phy_led_mdix_bist_control #(
    parameter STRETCH_CYCLES = `STRETCH_MS * `CLK_KHZ,
    parameter BLINK_CYCLES = `BLINK_MS * `CLK_KHZ
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    // wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [6:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // straps
    input wire strap_auto_crossover_i,
    input wire strap_led_mode_lo_i,
    // raw status from the phy core
    input wire link_good_i,
    input wire speed_100_i,
    input wire activity_i,
    input wire collision_i,
    input wire full_duplex_i,
    input wire [1:0] local_advertisement_i,
    input wire [1:0] partner_advertisement_i,
    // self-test engine
    input wire selftest_error_i,
    input wire selftest_done_i,
    output wire selftest_run_o,
    output wire selftest_sequence_select_o,
    output reg selftest_force_error_o,
    // crossover steering
    output wire auto_crossover_en_o,
    output wire force_crossover_o,
    // leds
    output reg link_led_pin_o,
    output reg speed_led_pin_o,
    output reg activity_collision_led_pin_o
);

// ============================================================
// register storage
reg [5:0] led_direct_override;
reg auto_crossover_en;
reg force_crossover;
reg selftest_sequence_select;
reg selftest_pass_flag;
reg selftest_run;
reg led_stretch_bypass;
reg [1:0] led_mode_select;
reg pause_rx;
reg pause_tx;
reg strap_take;

wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_req & wb_we_i;
wire wr_lo = wb_wr & wb_sel_i[0];
wire wr_hi = wb_wr & wb_sel_i[1];
wire [4:0] idx = wb_adr_i[6:2];
wire hit_led = (idx == `IDX_LED_OVR);
wire hit_misc = (idx == `IDX_MISC_CTL);

// ============================================================
// wishbone: one registered ack cycle per request, one clock after the request
// unmapped indices are still acknowledged so a master never hangs
always @(posedge ref_clk_i)
begin
    if (!rst_n_i)
        wb_ack_o <= 1'b0;
    else
        wb_ack_o <= wb_req;
end

// ============================================================
// strap capture happens on the first clock after reset release
always @(posedge ref_clk_i)
begin
    if (!rst_n_i)
        strap_take <= 1'b1;
    else
        strap_take <= 1'b0;
end

always @(posedge ref_clk_i)
begin
    if (!rst_n_i)
    begin
        led_direct_override <= 6'h00;
    end
    else if (hit_led && wr_lo)
    begin
        // bits 15:6 have no storage, so writes there are dropped
        led_direct_override[`LO_SPD_EN] <= wb_dat_i[`LO_SPD_EN];
        led_direct_override[`LO_LNK_EN] <= wb_dat_i[`LO_LNK_EN];
        led_direct_override[`LO_ACT_EN] <= wb_dat_i[`LO_ACT_EN];
        led_direct_override[`LO_SPD_VAL] <= wb_dat_i[`LO_SPD_VAL];
        led_direct_override[`LO_LNK_VAL] <= wb_dat_i[`LO_LNK_VAL];
        led_direct_override[`LO_ACT_VAL] <= wb_dat_i[`LO_ACT_VAL];
    end
end

always @(posedge ref_clk_i)
begin
    if (!rst_n_i)
    begin
        auto_crossover_en <= 1'b0;
        force_crossover <= 1'b0;
        selftest_sequence_select <= 1'b0;
        selftest_run <= 1'b0;
        led_stretch_bypass <= 1'b0;
        led_mode_select <= 2'h0;
        selftest_force_error_o <= 1'b0;
    end
    else
    begin
        selftest_force_error_o <= 1'b0;
        if (strap_take)
        begin
            auto_crossover_en <= strap_auto_crossover_i;
            led_mode_select[0] <= strap_led_mode_lo_i;
        end
        if (hit_misc && wr_hi)
        begin
            auto_crossover_en <= wb_dat_i[`MC_XOVER_EN];
            force_crossover <= wb_dat_i[`MC_FORCE_XOVER];
            selftest_force_error_o <= wb_dat_i[`MC_FORCE_ERR];
            selftest_sequence_select <= wb_dat_i[`MC_SEQ_SEL];
            selftest_run <= wb_dat_i[`MC_RUN];
        end
        if (hit_misc && wr_lo)
        begin
            led_stretch_bypass <= wb_dat_i[`MC_BYPASS];
            led_mode_select <= wb_dat_i[`MC_MODE_HI:`MC_MODE_LO];
        end
    end
end

// ============================================================
// self-test pass flag: set on done, cleared on error or when stopped
// an error in the same cycle as done keeps the fail
always @(posedge ref_clk_i)
begin
    if (!rst_n_i)
        selftest_pass_flag <= 1'b0;
    else if (!selftest_run)
        selftest_pass_flag <= 1'b0;
    else if (selftest_error_i)
        selftest_pass_flag <= 1'b0;
    else if (selftest_done_i)
        selftest_pass_flag <= 1'b1;
end

// ============================================================
// pause resolution, full duplex only
// registered so a read never catches the resolution mid-settle
wire l_sym = local_advertisement_i[0];
wire l_asym = local_advertisement_i[1];
wire p_sym = partner_advertisement_i[0];
wire p_asym = partner_advertisement_i[1];

always @(posedge ref_clk_i)
begin
    if (!rst_n_i)
    begin
        pause_rx <= 1'b0;
        pause_tx <= 1'b0;
    end
    else
    begin
        pause_rx <= full_duplex_i & ((l_sym & p_sym) |
            (l_sym & l_asym & ~p_sym & p_asym));
        pause_tx <= full_duplex_i & ((l_sym & p_sym) |
            (~l_sym & l_asym & p_sym & p_asym));
    end
end

// ============================================================
// read mux: stored bits only, never the led pins
wire [15:0] misc_rd = {auto_crossover_en, force_crossover, pause_rx,
    pause_tx, 1'b0, selftest_sequence_select, selftest_pass_flag,
    selftest_run, led_stretch_bypass, led_mode_select, 5'h00};

always @(posedge ref_clk_i)
begin
    if (!rst_n_i)
        wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
    begin
        if (hit_led)
            wb_dat_o <= {26'h000_0000, led_direct_override};
        else if (hit_misc)
            wb_dat_o <= {16'h0000, misc_rd};
        else
            wb_dat_o <= 32'h0000_0000;
    end
end

assign auto_crossover_en_o = auto_crossover_en;
assign force_crossover_o = force_crossover;
assign selftest_run_o = selftest_run;
assign selftest_sequence_select_o = selftest_sequence_select;

// ============================================================
// activity and collision stretchers and blink timer
// counters are 32 bits wide: both timing parameters must stay below 2**32
reg [31:0] blink_cnt;
reg blink_phase;
wire [1:0] raw_event = {collision_i, activity_i};
wire [1:0] stretched;

// one retriggerable stretcher per event; a single-cycle event stays
// visible for STRETCH_CYCLES more cycles
genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_stretch
        reg [31:0] cnt;
        always @(posedge ref_clk_i)
        begin
            if (!rst_n_i)
                cnt <= 32'h0000_0000;
            else if (raw_event[g])
                cnt <= STRETCH_CYCLES;
            else if (cnt != 32'h0000_0000)
                cnt <= cnt - 32'h0000_0001;
        end
        assign stretched[g] = raw_event[g] | (cnt != 32'h0000_0000);
    end
endgenerate

always @(posedge ref_clk_i)
begin
    if (!rst_n_i)
    begin
        blink_cnt <= 32'h0000_0000;
        blink_phase <= 1'b0;
    end
    else if (blink_cnt >= BLINK_CYCLES - 1)
    begin
        blink_cnt <= 32'h0000_0000;
        blink_phase <= ~blink_phase;
    end
    else
        blink_cnt <= blink_cnt + 32'h0000_0001;
end

// raw when bypassed, stretched otherwise
wire act_seen = led_stretch_bypass ? activity_i : stretched[0];
wire col_seen = led_stretch_bypass ? collision_i : stretched[1];
wire link_blink = link_good_i & ~(act_seen & blink_phase);

// ============================================================
// led mode decode and override
localparam MODE_1 = 3'b001;
localparam MODE_2 = 3'b010;
localparam MODE_3 = 3'b100;
reg [2:0] mode;
reg next_link;
reg next_act;

always @*
begin
    if (led_mode_select[0])
        mode = MODE_1;
    else if (led_mode_select[1])
        mode = MODE_3;
    else
        mode = MODE_2;
end

always @*
begin
    case (mode)
        MODE_1:
        begin
            next_link = link_good_i;
            next_act = act_seen;
        end
        MODE_2:
        begin
            next_link = link_blink;
            next_act = col_seen;
        end
        MODE_3:
        begin
            next_link = link_blink;
            next_act = full_duplex_i;
        end
        default:
        begin
            next_link = link_good_i;
            next_act = act_seen;
        end
    endcase
end

always @(posedge ref_clk_i)
begin
    if (!rst_n_i)
    begin
        link_led_pin_o <= 1'b0;
        speed_led_pin_o <= 1'b0;
        activity_collision_led_pin_o <= 1'b0;
    end
    else
    begin
        // software override wins over every mode and over stretching
        speed_led_pin_o <= led_direct_override[`LO_SPD_EN] ?
            led_direct_override[`LO_SPD_VAL] : speed_100_i;
        link_led_pin_o <= led_direct_override[`LO_LNK_EN] ?
            led_direct_override[`LO_LNK_VAL] : next_link;
        activity_collision_led_pin_o <= led_direct_override[`LO_ACT_EN] ?
            led_direct_override[`LO_ACT_VAL] : next_act;
    end
end

endmodule
`default_nettype wire

// *** tb/phy_led_props.sv ***
// assertion checker for the led override and misc control registers
`default_nettype none
module phy_led_props (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [6:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic selftest_force_error_o,
    input wire logic force_crossover_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================
    // helpers and properties
    wire logic [4:0] idx = wb_adr_i[6:2];
    wire logic rd = wb_ack_o && !wb_we_i;
    wire logic mw = wb_ack_o && wb_we_i && idx == 5'h19 && wb_sel_i[1];
    wire logic fe_wr = mw && wb_dat_i[11];
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // allow the stored value to reach the pin one cycle late
    sequence s_misc_wr;
        mw || $past(mw);
    endsequence
    a_ack_after_take: assert property (s_take |=> wb_ack_o)
        else $error("ack late");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_led_high_zero: assert property (
        rd && idx == 5'h18 |-> wb_dat_o[31:6] == 26'h000_0000)
        else $error("led reserved bits set");
    a_unmapped_zero: assert property (
        rd && idx != 5'h18 && idx != 5'h19 |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_dat_holds: assert property ($changed(wb_dat_o) |-> rd)
        else $error("read data moved");
    a_fe_one_pulse: assert property (
        selftest_force_error_o |=> !selftest_force_error_o)
        else $error("force error too long");
    a_fe_from_write: assert property (
        selftest_force_error_o |-> fe_wr)
        else $error("force error without write");
    a_xover_by_write: assert property (
        $changed(force_crossover_o) |-> s_misc_wr)
        else $error("crossover moved alone");
endmodule
bind phy_led_mdix_bist_control phy_led_props i_props (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .selftest_force_error_o(selftest_force_error_o),
    .force_crossover_o(force_crossover_o));
`default_nettype wire

// *** tb/led_panel.sv ***
// far side model: phy status source and the led panel
`default_nettype none
module led_panel (
    input wire logic ref_clk_i,
    input wire logic [4:0] st_i,
    input wire logic [2:0] led_i,
    output logic [4:0] st_o = 5'h00,
    output logic [2:0] seen_o = 3'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================
    // status moves only after an edge, as the core's flops would
    always @(posedge ref_clk_i)
    begin
        st_o <= st_i;
        seen_o <= led_i;
    end
endmodule
`default_nettype wire

// *** tb/phy_led_mdix_bist_control_test.sv ***
// self-checking bench for the led override and misc control registers
`default_nettype none
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("unexpected at %0t: %h vs %h", $time, g, e); \
        end \
    end
module phy_led_mdix_bist_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================
    // stimulus and design
    int miscompares = 0;
    int n_compared = 0;
    int nfe = 0;
    int ones = 0;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, sx = 0, sm = 0;
    logic err = 0, done = 0;
    logic [1:0] al = 2'h0, ap = 2'h0, m;
    logic [2:0] e;
    logic [3:0] sel = 4'h0;
    logic [4:0] st = 5'h00, s;
    logic [5:0] o;
    logic [6:0] adr = 7'h00;
    logic [31:0] wd = 32'h0000_0000, rd;
    wire [31:0] dat;
    wire [4:0] stm;
    wire [2:0] led, seen;
    wire ack, run, seq, fe, axen, fx;
    phy_led_mdix_bist_control #(.STRETCH_CYCLES(8), .BLINK_CYCLES(8))
    i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(dat), .wb_ack_o(ack), .strap_auto_crossover_i(sx),
        .strap_led_mode_lo_i(sm), .link_good_i(stm[4]), .speed_100_i(stm[3]),
        .activity_i(stm[2]), .collision_i(stm[1]), .full_duplex_i(stm[0]),
        .local_advertisement_i(al), .partner_advertisement_i(ap),
        .selftest_error_i(err), .selftest_done_i(done), .selftest_run_o(run),
        .selftest_sequence_select_o(seq), .selftest_force_error_o(fe),
        .auto_crossover_en_o(axen), .force_crossover_o(fx),
        .link_led_pin_o(led[2]), .speed_led_pin_o(led[1]),
        .activity_collision_led_pin_o(led[0]));
    led_panel i_panel (.ref_clk_i(clk), .st_i(st), .led_i(led), .st_o(stm),
        .seen_o(seen));
    initial forever #4 clk = ~clk;
    always @(posedge clk) nfe += fe;
    function automatic logic [15:0] pause(input logic [1:0] l, p,
        input logic fd);
        logic rx;
        logic tx;
        rx = fd & (l[0] & p[0] | l[0] & l[1] & ~p[0] & p[1]);
        tx = fd & (l[0] & p[0] | ~l[0] & l[1] & p[0] & p[1]);
        return {2'b00, rx, tx, 12'h000};
    endfunction
    function automatic logic [2:0] led_exp(input logic [5:0] v,
        input logic [1:0] md, input logic [4:0] x);
        logic a;
        a = md[0] ? x[2] : (md[1] ? x[0] : x[1]);
        return {v[4] ? v[1] : x[4], v[5] ? v[2] : x[3], v[3] ? v[0] : a};
    endfunction
    task automatic xfer(input logic w, input logic [4:0] ix,
        input logic [15:0] v);
        int t = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        sel <= 4'h3;
        adr <= {ix, 2'b00};
        wd <= {16'h0000, v};
        do
        begin
            @(posedge clk);
            t++;
        end
        while (ack !== 1'b1 && t < 20);
        `CHK(ack, 1'b1)
        rd = dat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask
    task automatic do_reset(input logic a, input logic b);
        sx <= a;
        sm <= b;
        rst_n <= 0;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
    endtask
    task automatic misc_case(input logic [15:0] v, input logic [1:0] l, p,
        input logic fd);
        al <= l;
        ap <= p;
        st <= {4'h0, fd};
        xfer(1, 5'h19, v);
        xfer(0, 5'h19, 16'h0000);
        `CHK(rd[15:0], v & 16'hC5E0 | pause(l, p, fd))
        `CHK({axen, fx, seq, run}, {v[15:14], v[10], v[8]})
    endtask
    task automatic kick(input logic bad);
        err <= bad;
        done <= !bad;
        @(posedge clk);
        err <= 0;
        done <= 0;
        @(posedge clk);
    endtask
    task end_of_test;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #40_000;
        miscompares++;
        end_of_test;
    end
    initial
    begin
        void'($urandom(32'h6ae8_450f));
        do_reset(1, 1);
        xfer(0, 5'h19, 16'h0000);
        `CHK(rd, 32'h0000_8020)
        xfer(0, 5'h18, 16'h0000);
        `CHK(rd, 32'h0000_0000)
        misc_case(16'hFFFF, 2'h3, 2'h3, 1'b1);
        misc_case(16'hFFFF, 2'h3, 2'h3, 1'b0);
        repeat (30)
            misc_case(16'($urandom), 2'($urandom), 2'($urandom), 1'($urandom));
        repeat (40)
        begin
            o = 6'($urandom);
            m = 2'($urandom);
            s = 5'($urandom);
            s[2] = s[2] & m[0];
            xfer(1, 5'h19, {8'h00, 1'b1, m, 5'h00});
            xfer(1, 5'h18, {10'h3FF, o});
            st <= s;
            repeat (4) @(posedge clk);
            e = led_exp(o, m, s);
            `CHK(seen[2], e[2])
            `CHK(seen[1], e[1])
            `CHK(seen[0], e[0])
            xfer(0, 5'h18, 16'h0000);
            `CHK(rd, {26'h000_0000, o})
        end
        st <= 5'h00;
        xfer(1, 5'h18, 16'h0000);
        for (int b = 0; b < 2; b++)
        begin
            xfer(1, 5'h19, {8'h00, 1'(b), 2'b01, 5'h00});
            repeat (12) @(posedge clk);
            st <= 5'h04;
            @(posedge clk);
            st <= 5'h00;
            repeat (6) @(posedge clk);
            `CHK(seen[0], b == 0)
            repeat (8) @(posedge clk);
            `CHK(seen[0], 1'b0)
        end
        for (int k = 0; k < 2; k++)
        begin
            xfer(1, 5'h19, {8'h00, 1'b1, 1'(k), 6'h00});
            st <= 5'h14;
            repeat (3) @(posedge clk);
            ones = 0;
            repeat (16)
            begin
                @(posedge clk);
                ones += seen[2];
            end
            `CHK(ones, 8)
        end
        nfe = 0;
        xfer(1, 5'h19, 16'h0800);
        repeat (3) @(posedge clk);
        `CHK(nfe, 1)
        xfer(1, 5'h19, 16'h0500);
        for (int i = 0; i < 4; i++)
        begin
            if (i < 3)
                kick(i == 1);
            else
                xfer(1, 5'h19, 16'h0000);
            xfer(0, 5'h19, 16'h0000);
            `CHK(rd[9], i == 0 || i == 2)
        end
        xfer(1, 5'h1A, 16'hFFFF);
        xfer(0, 5'h1A, 16'h0000);
        `CHK(rd, 32'h0000_0000)
        do_reset(0, 0);
        xfer(0, 5'h19, 16'h0000);
        `CHK(rd[15:0], pause(al, ap, st[0]))
        end_of_test;
    end
endmodule
`default_nettype wire
